// File: rtl/cde_consts.svh
// constants for the complement / decrement executor
`ifndef CDE_CONSTS_SVH
`define CDE_CONSTS_SVH

// instruction word fields
`define CDE_OP_MSB      11
`define CDE_OP_LSB      6
`define CDE_DEST_BIT    5
`define CDE_ADDR_MSB    4
`define CDE_ADDR_LSB    0

// six-bit opcode values in bits 11:6
`define CDE_OPC_INVERT    6'h09
`define CDE_OPC_DEC       6'h03
`define CDE_OPC_DEC_SKIP  6'h0b

// destination select values
`define CDE_DEST_ACC    1'h0
`define CDE_DEST_FILE   1'h1

// reset values
`define CDE_ADDR_RST    5'h00
`define CDE_DATA_RST    8'h00

`endif

// File: rtl/cde_pkg.sv
// types shared by the complement / decrement executor
package cde_pkg;

  // decoded operation class
  typedef enum logic [1:0] {
    OP_NONE,
    OP_INVERT,
    OP_DEC,
    OP_DEC_SKIP
  } op_kind_t;

  // execution sequencing state
  typedef enum logic {
    ST_RUN,
    ST_SKIP
  } exec_state_t;

  // one registered write-back bundle
  typedef struct packed {
    logic       acc_we;    // write accumulator
    logic       file_we;   // write addressed register
    logic [4:0] addr;      // register slot 0..31
    logic [7:0] data;      // result value
    logic       zf_we;     // update zero flag
    logic       zf;        // new zero flag value
  } wb_t;

endpackage

// File: rtl/complement_decrement_exec.sv
// executor for complement, decrement and decrement-skip-if-zero
`timescale 1ns/1ps
`include "cde_consts.svh"

// What this block does
// - complement op writes inverted register, updates zero
// - dest bit zero accumulator, one register
// - decrement op writes register minus one, zero
// - decrement-skip writes result, flags left untouched
// - decrement-skip destination chosen by dest bit
// - zero decrement-skip discards next, runs no-op

module complement_decrement_exec #(
  parameter int DATA_W = 8,  // data path width
  parameter int ADDR_W = 5   // register slot field width
) (
  input  wire logic               sys_clk,      // instruction clock
  input  wire logic               sys_rst,      // sync reset, high
  input  wire logic               instr_valid,  // instruction present
  input  wire logic [11:0]        instr,        // fetched word
  input  wire logic [DATA_W-1:0]  file_rd_data, // addressed register
  output cde_pkg::wb_t            wb,           // write-back bundle
  output logic                    discard,      // next word squashed
  output logic                    nop_exec      // no-op running now
);

  // the write-back struct is fixed at eight data bits, five address bits
  if (DATA_W != 8 || ADDR_W != 5) begin : g_check
    $error("complement_decrement_exec supports DATA_W=8, ADDR_W=5 only");
  end

  // decode of the six opcode bits, shared by datapath and checks
  function automatic cde_pkg::op_kind_t decode(input logic [11:0] w);
    logic [5:0] opc;
    opc = w[`CDE_OP_MSB:`CDE_OP_LSB];
    if (opc == `CDE_OPC_INVERT) begin
      decode = cde_pkg::OP_INVERT;
    end else if (opc == `CDE_OPC_DEC) begin
      decode = cde_pkg::OP_DEC;
    end else if (opc == `CDE_OPC_DEC_SKIP) begin
      decode = cde_pkg::OP_DEC_SKIP;
    end else begin
      decode = cde_pkg::OP_NONE;
    end
  endfunction

  cde_pkg::wb_t         wb_r;        // registered write-back
  cde_pkg::wb_t         wb_nxt;      // next write-back
  cde_pkg::exec_state_t state_r;     // run or squash slot
  cde_pkg::exec_state_t state_nxt;   // next state
  logic                 discard_r;   // squash marker
  logic                 discard_nxt; // next squash marker
  logic                 nop_r;       // no-op cycle marker
  logic                 nop_nxt;     // next no-op marker
  cde_pkg::op_kind_t    kind;        // decoded class this cycle
  logic [7:0]           result;      // computed value
  logic                 live;        // instruction actually executes

  // decode and compute, one instruction cycle per word
  always_comb begin
    kind   = decode(instr);
    // a word that arrives in the squash slot is never executed
    // gating on reset too keeps the check helpers quiet while the
    // registers are being cleared, at no cost to the datapath
    live   = instr_valid && !sys_rst
             && (state_r == cde_pkg::ST_RUN);
    result = `CDE_DATA_RST;
    if (kind == cde_pkg::OP_INVERT) begin
      result = ~file_rd_data;
    end else if (kind != cde_pkg::OP_NONE) begin
      result = file_rd_data - 8'h01;
    end
  end

  // next write-back, flags and squash sequencing
  always_comb begin
    wb_nxt      = '0;
    state_nxt   = cde_pkg::ST_RUN;
    discard_nxt = 1'h0;
    nop_nxt     = 1'h0;
    wb_nxt.addr = `CDE_ADDR_RST;
    wb_nxt.data = `CDE_DATA_RST;
    case (state_r)
      cde_pkg::ST_RUN: begin
        if (live && kind != cde_pkg::OP_NONE) begin
          // full five-bit slot passes straight through
          wb_nxt.addr = instr[`CDE_ADDR_MSB:`CDE_ADDR_LSB];
          wb_nxt.data = result;
          // destination select, same meaning for all three ops
          if (instr[`CDE_DEST_BIT] == `CDE_DEST_FILE) begin
            wb_nxt.file_we = 1'h1;
          end else begin
            wb_nxt.acc_we = 1'h1;
          end
          if (kind == cde_pkg::OP_DEC_SKIP) begin
            // flags untouched; skip only on a zero result
            wb_nxt.zf_we = 1'h0;
            if (result == `CDE_DATA_RST) begin
              state_nxt   = cde_pkg::ST_SKIP;
              discard_nxt = 1'h1;
            end
          end else begin
            wb_nxt.zf_we = 1'h1;
            wb_nxt.zf    = (result == `CDE_DATA_RST);
          end
        end
      end
      cde_pkg::ST_SKIP: begin
        // prefetched word dropped: this cycle is the no-op
        nop_nxt   = 1'h1;
        state_nxt = cde_pkg::ST_RUN;
      end
      default: begin
        state_nxt = cde_pkg::ST_RUN;
      end
    endcase
  end

  // registers only; every output leaves from here
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_r      <= '0;
      state_r   <= cde_pkg::ST_RUN;
      discard_r <= 1'h0;
      nop_r     <= 1'h0;
    end else begin
      wb_r      <= wb_nxt;
      state_r   <= state_nxt;
      discard_r <= discard_nxt;
      nop_r     <= nop_nxt;
    end
  end

  assign wb       = wb_r;
  assign discard  = discard_r;
  assign nop_exec = nop_r;

  // checks: a cycle's input word yields the write-back one edge later
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // helper: word taken for execution in this cycle
  // these share the datapath decode, so a wrong opcode constant
  // would slip past them; the bench model reads the same constants header
  logic take_inv;  // complement accepted
  logic take_dec;  // decrement accepted
  logic take_skip; // decrement-skip accepted
  assign take_inv  = live && kind == cde_pkg::OP_INVERT;
  assign take_dec  = live && kind == cde_pkg::OP_DEC;
  assign take_skip = live && kind == cde_pkg::OP_DEC_SKIP;

  // complement: inverse of the read value, zero flag from it
  invert_value_a: assert property (
    take_inv |=> wb.data == ~$past(file_rd_data)
      && wb.zf_we && wb.zf == (~$past(file_rd_data) == 8'h00))
    else $error("complement result or zero flag wrong");

  // destination bit steers the two single-cycle ops
  dest_select_a: assert property (
    (take_inv || take_dec) |=>
      wb.file_we == $past(instr[5]) && wb.acc_we == !$past(instr[5]))
    else $error("destination select not honoured");

  // decrement: read value minus one, wrapping at zero
  dec_value_a: assert property (
    take_dec |=> wb.data == $past(file_rd_data) - 8'h01
      && wb.zf_we && wb.zf == ($past(file_rd_data) == 8'h01))
    else $error("decrement result or zero flag wrong");

  // skip variant: same subtraction, flag write held off
  skip_flags_a: assert property (
    take_skip |=> !wb.zf_we
      && wb.data == $past(file_rd_data) - 8'h01)
    else $error("decrement-skip touched the flags");

  skip_dest_a: assert property (
    take_skip |=>
      wb.file_we == $past(instr[5]) && wb.acc_we == !$past(instr[5]))
    else $error("decrement-skip destination wrong");

  // the skip variant writes back to the slot it read, like the others
  skip_slot_a: assert property (
    take_skip |=> wb.addr == $past(instr[4:0]))
    else $error("decrement-skip wrote the wrong slot");

  // a zero result squashes the prefetched word, then a no-op slot
  skip_nop_a: assert property (
    take_skip && file_rd_data == 8'h01 |=>
      discard ##1 (nop_exec && !wb.acc_we && !wb.file_we && !discard))
    else $error("zero skip did not squash next word");

  no_skip_a: assert property (
    take_skip && file_rd_data != 8'h01 |=> !discard ##1 !nop_exec)
    else $error("nonzero skip squashed a word");

  // the dropped word must leave no trace in the write-back
  squash_quiet_a: assert property (
    discard |=> wb == '0 && nop_exec && !discard)
    else $error("squashed word was executed");

  // a no-op slot only ever follows a squash marker
  nop_cause_a: assert property (
    nop_exec |-> $past(discard))
    else $error("no-op slot without a squash");

  // single-cycle ops never open a squash slot
  one_cycle_a: assert property (
    (take_inv || take_dec) |=>
      !discard && wb.addr == $past(instr[4:0]) ##1 !nop_exec)
    else $error("single-cycle op took extra cycle or lost slot");

  // reset outranks everything, so the default disable is off here
  reset_quiet_a: assert property (
    disable iff (1'h0) sys_rst |=> wb == '0 && !discard && !nop_exec)
    else $error("outputs not cleared by reset");

  // main scenarios: each op kind, a taken skip, two skips in a row
  cover_inv_file_c: cover property (take_inv && instr[5]);
  cover_dec_zero_c: cover property (take_dec && file_rd_data == 8'h01);
  cover_skip_taken_c: cover property (
    take_skip && file_rd_data == 8'h01 ##1 discard ##1 nop_exec);
  // a fresh skip accepted in the very no-op slot
  cover_skip_pair_c: cover property (
    take_skip && file_rd_data == 8'h01 ##2 (nop_exec && take_skip));

endmodule

// File: bench/complement_decrement_exec_test.sv
// self-checking bench for the complement / decrement executor
`timescale 1ns/1ps
`include "cde_consts.svh"

module complement_decrement_exec_test;
  logic         sys_clk;      // instruction clock
  logic         sys_rst;      // sync reset, high
  logic         instr_valid;  // word present
  logic [11:0]  instr;        // fetched word
  logic [7:0]   file_rd_data; // addressed register contents
  cde_pkg::wb_t wb;           // write-back seen
  logic         discard;      // squash seen
  logic         nop_exec;     // no-op seen
  cde_pkg::wb_t e_wb;         // model write-back
  logic         e_disc;       // model squash
  logic         e_nop;        // model no-op
  int           n_mismatch;   // failed compares
  int           compares;     // all compares
  int           seed;         // random seed
  int           cycles;       // timeout counter
  logic [31:0]  r;            // random draw
  logic [5:0]   pick;         // drawn opcode

  complement_decrement_exec #(
    .DATA_W (8),
    .ADDR_W (5)
  ) u_complement_decrement_exec (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .instr_valid  (instr_valid),
    .instr        (instr),
    .file_rd_data (file_rd_data),
    .wb           (wb),
    .discard      (discard),
    .nop_exec     (nop_exec)
  );

  // clock generator, 25 ns period
  always #12.5 sys_clk = ~sys_clk;

  // reference model sees what the design samples on the same edge
  always @(posedge sys_clk) begin
    logic [5:0] opc;
    logic [7:0] res;
    logic       tk;
    opc = instr[11:6];
    res = (opc == `CDE_OPC_INVERT) ? ~file_rd_data : file_rd_data - 8'h01;
    // a squash slot never executes, whatever word sits there
    tk  = !sys_rst && instr_valid && !e_disc && (opc == `CDE_OPC_INVERT ||
          opc == `CDE_OPC_DEC || opc == `CDE_OPC_DEC_SKIP);
    e_nop  <= !sys_rst && e_disc;
    e_disc <= tk && opc == `CDE_OPC_DEC_SKIP && res == 8'h00;
    e_wb   <= '0;
    if (tk) begin
      e_wb.acc_we  <= instr[5] == `CDE_DEST_ACC;
      e_wb.file_we <= instr[5] == `CDE_DEST_FILE;
      e_wb.addr    <= instr[4:0];
      e_wb.data    <= res;
      e_wb.zf_we   <= opc != `CDE_OPC_DEC_SKIP;
      e_wb.zf      <= opc != `CDE_OPC_DEC_SKIP && res == 8'h00;
    end
    cycles <= cycles + 1;
    // guard against a hung run
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // outputs are settled mid-cycle; zf only matters when written
  always @(negedge sys_clk) if (cycles > 1) begin
    check({15'h0000, wb.acc_we}, {15'h0000, e_wb.acc_we});
    check({15'h0000, wb.file_we}, {15'h0000, e_wb.file_we});
    check({11'h000, wb.addr}, {11'h000, e_wb.addr});
    check({8'h00, wb.data}, {8'h00, e_wb.data});
    check({15'h0000, wb.zf_we}, {15'h0000, e_wb.zf_we});
    check({15'h0000, wb.zf & e_wb.zf_we}, {15'h0000, e_wb.zf});
    check({14'h0000, discard, nop_exec}, {14'h0000, e_disc, e_nop});
  end

  task automatic drive(input logic        v,
                       input logic [11:0] w,
                       input logic [7:0]  d);
    instr_valid  <= v;
    instr        <= w;
    file_rd_data <= d;
    @(posedge sys_clk);
  endtask

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // directed corner words, then random traffic with one mid-run reset
  initial begin
    sys_clk = 1'h0;
    sys_rst = 1'h1;
    instr_valid = 1'h0;
    instr = 12'h000;
    file_rd_data = 8'h00;
    n_mismatch = 0;
    compares = 0;
    cycles = 0;
    seed = 15346;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'h0;
    drive(1'h1, 12'h265, 8'h13);
    drive(1'h1, 12'h0e5, 8'h01);
    drive(1'h1, 12'h2c3, 8'h01);
    drive(1'h1, 12'h265, 8'h00);
    drive(1'h1, 12'h2ff, 8'h05);
    drive(1'h1, 12'h2e0, 8'h01);
    drive(1'h1, 12'h2e0, 8'h01);
    drive(1'h1, 12'h000, 8'h01);
    for (int i = 0; i < 1500; i++) begin
      r = $random(seed);
      pick = r[1] ? (r[0] ? `CDE_OPC_DEC_SKIP : `CDE_OPC_DEC) :
             (r[0] ? `CDE_OPC_INVERT : r[13:8]);
      sys_rst <= (i >= 700 && i < 702);
      drive(r[30:28] != 3'h0, {pick, r[5], r[20:16]},
            r[3] ? (r[2] ? r[27:20] : 8'hff) : {7'h00, r[2]});
    end
    report_and_stop();
  end
endmodule
